//--- design/cos_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Constants and carriers of the output shutdown control block
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes:   Field positions are bit indices inside each register word
//////////////////////////////////////////////////////////////////////////////
package cos_pkg;

   // Register byte offsets
   localparam logic [7:0] COS_CTL2_OFS = 8'h00;
   localparam logic [7:0] COS_CTL3_OFS = 8'h04;
   localparam logic [7:0] COS_STAT_OFS = 8'h08;

   // Control 2 field positions
   localparam int COS_C2_GSM_POS = 22;
   localparam int COS_C2_RSEN_POS = 15;
   localparam int COS_C2_GM_POS = 14;
   localparam int COS_C2_SWF_POS = 12;
   localparam int COS_C2_SRC_POS = 0;

   // Control 3 field positions
   localparam int COS_C3_HOLD_POS = 31;
   localparam int COS_C3_OSC_POS = 28;
   localparam int COS_C3_MODE_POS = 24;
   localparam int COS_C3_POL1_POS = 21;
   localparam int COS_C3_POL2_POS = 20;
   localparam int COS_C3_PSS1_POS = 18;
   localparam int COS_C3_PSS2_POS = 16;
   localparam int COS_C3_DT_POS = 0;

   // Status field positions
   localparam int COS_ST_WIP_POS = 16;
   localparam int COS_ST_ARM_POS = 10;
   localparam int COS_ST_TRIG_POS = 7;
   localparam int COS_ST_TSET_POS = 6;
   localparam int COS_ST_TCLR_POS = 5;
   localparam int COS_ST_SD_POS = 4;

   // Reserved shutdown source enable bit
   localparam logic [7:0] COS_SRC_RSVD_MASK = 8'h04;

   // Output mode codes
   localparam logic [2:0] COS_MODE_STEER = 3'h0;
   localparam logic [2:0] COS_MODE_PUSHPULL = 3'h1;
   localparam logic [2:0] COS_MODE_HALFBR = 3'h2;
   localparam logic [2:0] COS_MODE_BDC_REV = 3'h4;
   localparam logic [2:0] COS_MODE_BDC_FWD = 3'h5;
   localparam logic [2:0] COS_MODE_SCAN = 3'h6;

   // Capture gating source modes
   localparam logic [1:0] COS_GSM_LEVEL = 2'h0;
   localparam logic [1:0] COS_GSM_RISE = 2'h1;
   localparam logic [1:0] COS_GSM_FALL = 2'h2;

   // Last output index in scan mode
   localparam logic [2:0] COS_SCAN_LAST = 3'h5;

   typedef struct packed {
      logic [1:0] capture_gating_source_mode;
      logic auto_restart_enable;
      logic shutdown_gate_mode;
      logic software_shutdown_force;
      logic [7:0] shutdown_source_enables;
   } cos_ctl2_t;

   typedef struct packed {
      logic output_hold_until_trigger;
      logic [2:0] one_shot_extend_count;
      logic [2:0] output_mode_select;
      logic polarity_group_one;
      logic polarity_group_two;
      logic [1:0] shutdown_state_group_one;
      logic [1:0] shutdown_state_group_two;
      logic [5:0] dead_time_periods;
   } cos_ctl3_t;

   localparam cos_ctl2_t COS_CTL2_RST = '0;
   localparam cos_ctl3_t COS_CTL3_RST = '0;

endpackage

//--- design/cos_sync.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Two-flop synchroniser for levels from outside the clock domain
// Assumes: Inputs are slow levels, not pulses
// Notes:   Only the second flop is visible to other logic
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module cos_sync #(
   parameter int W = 1
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule // cos_sync

//--- design/cos_dead_time.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Dead-time insertion for one complementary output pair
// Assumes: One dead-time delay period is one sys_clk cycle
// Notes:   Both outputs are inactive for the whole dead interval
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module cos_dead_time
   import cos_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic pwm_in,
   input wire logic [5:0] dt_periods,
   output logic hi_q,
   output logic lo_q
);
   logic prev_q;
   logic [5:0] cnt_q;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         prev_q <= 1'b0;
         cnt_q <= 6'h00;
         hi_q <= 1'b0;
         lo_q <= 1'b0;
      end else if (pwm_in != prev_q) begin
         prev_q <= pwm_in;
         if (dt_periods == 6'h00) begin // R10
            hi_q <= pwm_in;
            lo_q <= !pwm_in;
         end else begin
            cnt_q <= dt_periods; // R10
            hi_q <= 1'b0;
            lo_q <= 1'b0;
         end
      end else if (cnt_q != 6'h00) begin
         cnt_q <= cnt_q - 6'h01;
         if (cnt_q == 6'h01) begin
            hi_q <= prev_q;
            lo_q <= !prev_q;
         end
      end else begin
         hi_q <= prev_q;
         lo_q <= !prev_q;
      end
   end

   dead_gap_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R10
      (pwm_in != prev_q) && (dt_periods == 6'h02) |=>
         (!hi_q && !lo_q) [*2] ##1 (hi_q != lo_q))
      else $error("dead interval not two periods");
endmodule // cos_dead_time

//--- design/cos_top.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Output stage, auto-shutdown, trigger and status of a CCP unit
// Assumes: Timer events arrive as one-cycle pulses on sys_clk
// Notes:   Registers reached over AHB-Lite, zero wait states
//
// Overview of operation
// R01: Gate mode set delays shutdown to next rollover; clear means immediate.
// R02: Software force acts as a shutdown source, still obeying gate mode.
// R03: Eight source enables pick fault pins, logic cell, siblings, comparators; enable bit 2 is reserved and ignored.
// R04: Hold-until-trigger leaves enabled pins undriven until triggered; hold does not apply during shutdown.
// R05: One-shot event lasts count plus one timer count periods.
// R06: Output mode selects steer, push-pull, half-bridge, brush DC, scan.
// R07: Polarity bits make each output group active-low when set.
// R08: Group one shutdown state: 11 active, 10 inactive, 0x high-Z.
// R09: Group two shutdown state uses the same encoding.
// R10: Dead-time field inserts that many periods; zero disables it.
// R11: Mode, group two polarity, state and dead time exist only multi-output.
// R12: Five write-pending flags show buffered updates in progress.
// R13: Writing one arms one-shot capture gating; location reads zero.
// R14: Trigger status reads one while timer triggered and running.
// R15: Trigger-set write triggers timer when triggered operation enabled.
// R16: Trigger-clear write cancels trigger when triggered operation enabled.
// R17: Shutdown flag reads one during shutdown; software may clear it.
// R18: Unimplemented status and control bits read as zero.
// R19: Auto restart clears shutdown flag at next period after input ends.
// R20: Gating mode 10 falling disables, 01 rising enables, 00 follows level.
// R21: Any enabled active source or force sets the shutdown flag.
// R22: Polarity applies after dead time, also to shutdown states.
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module cos_top
   import cos_pkg::*;
#(
   parameter bit MULTI_OUTPUT = 1'b1
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic fault_pin_a,
   input wire logic fault_pin_b,
   input wire logic comparator_1,
   input wire logic comparator_2,
   input wire logic logic_cell_out,
   input wire logic sibling_out_1,
   input wire logic sibling_out_2,
   input wire logic pwm_level,
   input wire logic tb_rollover,
   input wire logic period_start,
   input wire logic tb_tick,
   input wire logic hw_trigger,
   input wire logic one_shot_event,
   input wire logic triggered_operation_enable,
   input wire logic [5:0] output_enables,
   input wire logic [4:0] write_pending,
   output logic [5:0] pwm_pin,
   output logic [5:0] pwm_oe,
   output logic trigger_status,
   output logic shutdown_active_flag,
   output logic one_shot_active,
   output logic capture_disable
);
   //////////////////////////////////////////////////////////////////////////
   cos_ctl2_t ctl2_q;
   cos_ctl3_t ctl3_q;
   logic wr_pend_q;
   logic [7:0] wr_addr_q;
   logic addr_ok, wr_ctl2, wr_ctl3, wr_stat;
   logic [31:0] rd_d;
   logic arm_q, src_prev_q, pp_phase_q;
   logic [2:0] scan_idx_q, os_cnt_q;
   assign addr_ok = hsel && htrans[1] && hready;
   assign wr_ctl2 = wr_pend_q && (wr_addr_q == COS_CTL2_OFS);
   assign wr_ctl3 = wr_pend_q && (wr_addr_q == COS_CTL3_OFS);
   assign wr_stat = wr_pend_q && (wr_addr_q == COS_STAT_OFS);
   // Writes land in the data phase, one cycle after the address
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
      end else begin
         wr_pend_q <= addr_ok && hwrite;
         wr_addr_q <= haddr[7:0];
      end
   end
   always_comb begin
      rd_d = 32'h0000_0000; // R18
      unique case (haddr[7:0])
         COS_CTL2_OFS: begin
            rd_d[COS_C2_GSM_POS +: 2] = ctl2_q.capture_gating_source_mode;
            rd_d[COS_C2_RSEN_POS] = ctl2_q.auto_restart_enable;
            rd_d[COS_C2_GM_POS] = ctl2_q.shutdown_gate_mode;
            rd_d[COS_C2_SWF_POS] = ctl2_q.software_shutdown_force;
            rd_d[COS_C2_SRC_POS +: 8] = ctl2_q.shutdown_source_enables;
         end
         COS_CTL3_OFS: begin
            rd_d[COS_C3_HOLD_POS] = ctl3_q.output_hold_until_trigger;
            rd_d[COS_C3_OSC_POS +: 3] = ctl3_q.one_shot_extend_count;
            rd_d[COS_C3_MODE_POS +: 3] = ctl3_q.output_mode_select;
            rd_d[COS_C3_POL1_POS] = ctl3_q.polarity_group_one;
            rd_d[COS_C3_POL2_POS] = ctl3_q.polarity_group_two;
            rd_d[COS_C3_PSS1_POS +: 2] = ctl3_q.shutdown_state_group_one;
            rd_d[COS_C3_PSS2_POS +: 2] = ctl3_q.shutdown_state_group_two;
            rd_d[COS_C3_DT_POS +: 6] = ctl3_q.dead_time_periods;
         end
         COS_STAT_OFS: begin
            rd_d[COS_ST_WIP_POS +: 5] = write_pending; // R12
            rd_d[COS_ST_TRIG_POS] = trigger_status; // R14
            rd_d[COS_ST_SD_POS] = shutdown_active_flag; // R17
         end
         default: rd_d = 32'h0000_0000;
      endcase
   end
   // Read data is sampled at the address phase; response always OKAY
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         if (addr_ok && !hwrite) begin
            hrdata <= rd_d;
         end
      end
   end
   //////////////////////////////////////////////////////////////////////////
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctl2_q <= COS_CTL2_RST;
      end else if (wr_ctl2) begin
         ctl2_q.capture_gating_source_mode <= hwdata[COS_C2_GSM_POS +: 2];
         ctl2_q.auto_restart_enable <= hwdata[COS_C2_RSEN_POS];
         ctl2_q.shutdown_gate_mode <= hwdata[COS_C2_GM_POS];
         ctl2_q.software_shutdown_force <= hwdata[COS_C2_SWF_POS];
         ctl2_q.shutdown_source_enables <= hwdata[COS_C2_SRC_POS +: 8];
      end
   end
   // The single-output variant keeps the multi-output fields at zero
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctl3_q <= COS_CTL3_RST;
      end else if (wr_ctl3) begin
         ctl3_q.output_hold_until_trigger <= hwdata[COS_C3_HOLD_POS];
         ctl3_q.one_shot_extend_count <= hwdata[COS_C3_OSC_POS +: 3];
         ctl3_q.polarity_group_one <= hwdata[COS_C3_POL1_POS];
         ctl3_q.shutdown_state_group_one <= hwdata[COS_C3_PSS1_POS +: 2];
         if (MULTI_OUTPUT) begin // R11
            ctl3_q.output_mode_select <= hwdata[COS_C3_MODE_POS +: 3];
            ctl3_q.polarity_group_two <= hwdata[COS_C3_POL2_POS];
            ctl3_q.shutdown_state_group_two <= hwdata[COS_C3_PSS2_POS +: 2];
            ctl3_q.dead_time_periods <= hwdata[COS_C3_DT_POS +: 6];
         end
      end
   end
   //////////////////////////////////////////////////////////////////////////
   logic [3:0] pin_s;
   logic [7:0] src_vec;
   logic src_hit, sd_req, sd_set, sd_clr;
   // Pins and comparators are asynchronous to sys_clk
   cos_sync #(.W(4)) u_sync (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .d({fault_pin_b, fault_pin_a, comparator_2, comparator_1}),
      .q(pin_s)
   );
   assign src_vec = {pin_s[3], pin_s[2], logic_cell_out, sibling_out_1,
                     sibling_out_2, 1'b0, pin_s[1], pin_s[0]};
   assign src_hit = |(src_vec & ctl2_q.shutdown_source_enables
                      & ~COS_SRC_RSVD_MASK); // R03
   assign sd_req = src_hit || ctl2_q.software_shutdown_force; // R02 R21
   assign sd_set = sd_req
                   && (!ctl2_q.shutdown_gate_mode || tb_rollover); // R01
   assign sd_clr = (wr_stat && !hwdata[COS_ST_SD_POS])
                   || (ctl2_q.auto_restart_enable && !sd_req
                       && period_start); // R19
   // A new event outweighs a clear in the same cycle
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         shutdown_active_flag <= 1'b0;
      end else if (sd_set) begin
         shutdown_active_flag <= 1'b1; // R17 R21
      end else if (sd_clr) begin
         shutdown_active_flag <= 1'b0; // R17
      end
   end
   //////////////////////////////////////////////////////////////////////////
   logic trig_set, trig_clr;
   assign trig_set = triggered_operation_enable
                     && (hw_trigger
                         || (wr_stat && hwdata[COS_ST_TSET_POS])); // R15
   assign trig_clr = triggered_operation_enable
                     && wr_stat && hwdata[COS_ST_TCLR_POS]; // R16
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         trigger_status <= 1'b0;
      end else if (trig_set) begin
         trigger_status <= 1'b1; // R14
      end else if (trig_clr) begin
         trigger_status <= 1'b0; // R14
      end
   end
   // The event counts whole timer periods, so it may start mid-period
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         one_shot_active <= 1'b0;
         os_cnt_q <= 3'h0;
      end else if (one_shot_event) begin
         one_shot_active <= 1'b1;
         os_cnt_q <= ctl3_q.one_shot_extend_count; // R05
      end else if (one_shot_active && tb_tick) begin
         if (os_cnt_q == 3'h0) begin
            one_shot_active <= 1'b0; // R05
         end else begin
            os_cnt_q <= os_cnt_q - 3'h1; // R05
         end
      end
   end
   //////////////////////////////////////////////////////////////////////////
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         arm_q <= 1'b0;
         src_prev_q <= 1'b0;
         capture_disable <= 1'b0;
      end else begin
         src_prev_q <= sd_req;
         unique case (ctl2_q.capture_gating_source_mode)
            COS_GSM_LEVEL: capture_disable <= !sd_req; // R20
            COS_GSM_RISE: begin
               if (arm_q && sd_req && !src_prev_q) begin
                  capture_disable <= 1'b0; // R20
               end
            end
            COS_GSM_FALL: begin
               if (arm_q && !sd_req && src_prev_q) begin
                  capture_disable <= 1'b1; // R20
               end
            end
            default: capture_disable <= capture_disable;
         endcase
         if (wr_stat && hwdata[COS_ST_ARM_POS]
             && (ctl2_q.capture_gating_source_mode == COS_GSM_RISE
                 || ctl2_q.capture_gating_source_mode == COS_GSM_FALL)) begin
            arm_q <= 1'b1; // R13
         end else if (arm_q && (sd_req != src_prev_q)) begin
            arm_q <= 1'b0;
         end
      end
   end
   //////////////////////////////////////////////////////////////////////////
   logic dt_hi, dt_lo, hold;
   logic [5:0] act, present;
   cos_dead_time u_dead (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .pwm_in(pwm_level),
      .dt_periods(ctl3_q.dead_time_periods),
      .hi_q(dt_hi),
      .lo_q(dt_lo)
   );
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pp_phase_q <= 1'b0;
         scan_idx_q <= 3'h0;
      end else if (period_start) begin
         pp_phase_q <= !pp_phase_q;
         if (scan_idx_q == COS_SCAN_LAST) begin
            scan_idx_q <= 3'h0;
         end else begin
            scan_idx_q <= scan_idx_q + 3'h1;
         end
      end
   end
   always_comb begin
      act = 6'h00;
      unique case (ctl3_q.output_mode_select) // R06
         COS_MODE_STEER: act = {6{pwm_level}};
         COS_MODE_PUSHPULL: act = {4'h0, pwm_level && pp_phase_q,
                                   pwm_level && !pp_phase_q};
         COS_MODE_HALFBR: act = {4'h0, dt_lo, dt_hi}; // R10
         COS_MODE_BDC_REV: act = {3'h0, 1'b1, pwm_level, 1'b0};
         COS_MODE_BDC_FWD: act = {2'h0, pwm_level, 2'h0, 1'b1};
         COS_MODE_SCAN: act[scan_idx_q] = pwm_level;
         default: act = 6'h00;
      endcase
   end
   assign present = MULTI_OUTPUT ? 6'h3f : 6'h01; // R11
   assign hold = ctl3_q.output_hold_until_trigger
                 && triggered_operation_enable && !trigger_status; // R04
   // Polarity is the last stage so shutdown states follow it too
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pwm_pin <= 6'h00;
         pwm_oe <= 6'h00;
      end else begin
         for (int i = 0; i < 6; i++) begin
            logic pol;
            logic [1:0] pss;
            pol = i[0] ? ctl3_q.polarity_group_two
                       : ctl3_q.polarity_group_one; // R07
            pss = i[0] ? ctl3_q.shutdown_state_group_two
                       : ctl3_q.shutdown_state_group_one;
            if (shutdown_active_flag) begin
               pwm_pin[i] <= pss[0] ^ pol; // R08 R09 R22
               pwm_oe[i] <= pss[1] && output_enables[i]
                            && present[i]; // R08 R09
            end else begin
               pwm_pin[i] <= act[i] ^ pol; // R22
               pwm_oe[i] <= output_enables[i] && present[i]
                            && !hold; // R04
            end
         end
      end
   end
   //////////////////////////////////////////////////////////////////////////
   sequence sd_wait_s;
      ctl2_q.shutdown_gate_mode && sd_req && !tb_rollover
      && !shutdown_active_flag;
   endsequence
   sequence os_last_s;
      one_shot_active && (os_cnt_q == 3'h0) && tb_tick && !one_shot_event;
   endsequence
   sd_immediate_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !ctl2_q.shutdown_gate_mode && src_hit |=> shutdown_active_flag) // R01
      else $error("shutdown not immediate");
   sd_gated_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      sd_wait_s |=> !shutdown_active_flag) // R01
      else $error("gated shutdown came before rollover");
   sw_force_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      ctl2_q.software_shutdown_force && !ctl2_q.shutdown_gate_mode
      |=> shutdown_active_flag [*2]) // R02
      else $error("software force did not hold shutdown");
   pss_inactive_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      shutdown_active_flag && output_enables[0]
      && ctl3_q.shutdown_state_group_one == 2'h2
      |=> pwm_oe[0] && (pwm_pin[0] == $past(ctl3_q.polarity_group_one))) // R08
      else $error("group one inactive state wrong");
   pss_highz_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      shutdown_active_flag && !ctl3_q.shutdown_state_group_two[1]
      |=> !pwm_oe[1]) // R09
      else $error("group two not released");
   stat_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      addr_ok && !hwrite && haddr[7:0] == COS_STAT_OFS
      |=> hrdata[15:8] == 8'h00 && hrdata[6:5] == 2'h0) // R18
      else $error("status reserved or strobe bits read nonzero");
   trig_hw_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      triggered_operation_enable && hw_trigger |=> trigger_status) // R14
      else $error("hardware trigger lost");
   os_end_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      os_last_s |=> !one_shot_active) // R05
      else $error("one-shot overran its count");
   restart_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      shutdown_active_flag && ctl2_q.auto_restart_enable && !sd_req
      && period_start |=> !shutdown_active_flag) // R19
      else $error("auto restart did not clear shutdown");
   hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      hold && !shutdown_active_flag |=> pwm_oe == 6'h00) // R04
      else $error("pins driven before trigger");
endmodule // cos_top

//--- testbench/cos_load.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Power stage loads on the six output pins
// Assumes: No pull resistors on the pads
// Notes:   A released pad toggles so that stale values never look valid
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module cos_load (
   input wire logic sys_clk,
   input wire logic [5:0] pwm_pin,
   input wire logic [5:0] pwm_oe,
   output logic [5:0] pad
);
   logic [5:0] last_q;
   always_ff @(posedge sys_clk) begin
      last_q <= pad;
   end
   assign pad = (pwm_oe & pwm_pin) | (~pwm_oe & ~last_q);
endmodule // cos_load

//--- testbench/ccp_output_shutdown_control_bench.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Self-checking bench of the output shutdown control block
// Assumes: Single AHB-Lite slave, hready tied to hreadyout
// Notes:   Source levels are driven as one vector, bit 0 is comparator 1
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module ccp_output_shutdown_control_bench;
   import cos_pkg::*;
   logic sys_clk = 0, rst_b = 0, hsel = 0, hwrite = 0, toe = 0;
   logic [31:0] haddr = 0, hwdata = 0, rd, hrdata;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 3'h2;
   logic [7:0] src = 0;
   logic pwm_level = 1, tb_rollover = 0, tb_tick = 0, one_shot_event = 0;
   logic [5:0] oen = 6'h3f, pwm_pin, pwm_oe, pad;
   logic [4:0] wp = 0;
   logic hreadyout, hresp, trigger_status, sd_flag, osa, cdis;
   int mismatches = 0, n_compared = 0;
   logic [7:0] ra[4] = '{8'h00, 8'h04, 8'h0c, 8'h00};
   logic [31:0] rw[4] = '{32'hffffffff, 32'hffffffff, 32'hffffffff, 0};
   logic [31:0] re[4] = '{32'h00c0d0ff, 32'hf73f003f, 32'h0, 32'h0};
   ////////////////////////////////////////////////////////////////////////////
   cos_top uut (.sys_clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
      .fault_pin_a(src[6]), .fault_pin_b(src[7]), .comparator_1(src[0]),
      .comparator_2(src[1]), .logic_cell_out(src[5]),
      .sibling_out_1(src[4]), .sibling_out_2(src[3]), .pwm_level,
      .tb_rollover, .period_start(tb_rollover), .tb_tick,
      .hw_trigger(src[2]), .one_shot_event,
      .triggered_operation_enable(toe), .output_enables(oen),
      .write_pending(wp), .pwm_pin, .pwm_oe, .trigger_status,
      .shutdown_active_flag(sd_flag), .one_shot_active(osa),
      .capture_disable(cdis));
   cos_load load (.sys_clk, .pwm_pin, .pwm_oe, .pad);
   initial begin
      forever #25 sys_clk = ~sys_clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      hsel <= 1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      hsel <= 0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task stop_test;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      cyc(4000);
      mismatches++; // Hang: counts as a failure
      stop_test;
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      cyc(2);
      rst_b <= 1;
      bus(0, 8'h04, 0); chk(rd, 0);
      for (int i = 0; i < 4; i++) begin
         bus(1, ra[i], rw[i]);
         bus(0, ra[i], 0); chk(rd, re[i]);
      end
      wp <= 5'h15;
      bus(0, 8'h08, 0); chk(rd, 32'h00150000);
      toe <= 1;
      bus(1, 8'h08, 32'h50);
      bus(0, 8'h08, 0); chk(rd, 32'h00150080);
      bus(1, 8'h08, 32'h30);
      bus(0, 8'h08, 0); chk(rd, 32'h00150000);
      $display("registers done");
      // Group one active-low, inactive in shutdown, comparator 1 enabled
      bus(1, 8'h04, 32'h00280000);
      bus(1, 8'h00, 32'h1);
      cyc(4); chk(pad[0], 0);
      @(posedge sys_clk) src[0] <= 1;
      cyc(4); chk(sd_flag, 1);
      chk({pwm_oe[0], pad[0]}, 2'b11);
      bus(0, 8'h08, 0); chk(rd, 32'h00150010);
      @(posedge sys_clk) src[0] <= 0;
      cyc(4);
      bus(1, 8'h08, 0);
      cyc(2); chk(sd_flag, 0);
      bus(1, 8'h00, 32'h1000);
      cyc(2); chk(sd_flag, 1);
      bus(1, 8'h00, 32'h4001);
      bus(1, 8'h08, 0);
      cyc(2); chk(sd_flag, 0);
      @(posedge sys_clk) src[0] <= 1;
      cyc(6); chk(sd_flag, 0);
      @(posedge sys_clk) tb_rollover <= 1;
      @(posedge sys_clk) tb_rollover <= 0;
      cyc(2); chk(sd_flag, 1);
      $display("shutdown done");
      chk(cdis, 0);
      @(posedge sys_clk) src[0] <= 0;
      cyc(4); chk(cdis, 1);
      bus(1, 8'h08, 0);
      bus(1, 8'h04, 32'h02000002);
      @(posedge sys_clk) pwm_level <= 0;
      cyc(3); chk(pad[1:0], 2'b00);
      cyc(1); chk(pad[1:0], 2'b10);
      @(posedge sys_clk) src[2] <= 1;
      @(posedge sys_clk) src[2] <= 0;
      cyc(1); chk(trigger_status, 1);
      bus(1, 8'h04, 32'h20000000);
      @(posedge sys_clk) one_shot_event <= 1;
      @(posedge sys_clk) one_shot_event <= 0;
      for (int k = 0; k < 3; k++) begin
         cyc(0); chk(osa, 1);
         @(posedge sys_clk) tb_tick <= 1;
         @(posedge sys_clk) tb_tick <= 0;
      end
      cyc(1); chk(osa, 0);
      bus(1, 8'h00, 32'h00400001);
      bus(1, 8'h08, 32'h410);
      @(posedge sys_clk) src[0] <= 1;
      cyc(4); chk(cdis, 0);
      $display("outputs done");
      rst_b <= 0;
      cyc(1); chk(sd_flag, 0);
      chk(trigger_status, 0);
      rst_b <= 1;
      bus(0, 8'h00, 0); chk(rd, 0);
      $display("reset done");
      stop_test;
   end
endmodule // ccp_output_shutdown_control_bench
